/* File: hw/bft_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bft_defs.svh"
module bft_top #(
  parameter int MAG_W = `BFT_MAG_W,
  parameter int DLY_W = `BFT_DLY_W,
  parameter int NSIG = 8,
  parameter int TICK_CYC = `BFT_TICK_CYC
) (
  input wire logic sys_clk, // 40 MHz clock
  input wire logic reset, // sync reset, active high
  input wire logic [MAG_W-1:0] phase_a_mag, // phase magnitudes
  input wire logic [MAG_W-1:0] phase_b_mag, // in 0.001 nominal
  input wire logic [MAG_W-1:0] phase_c_mag, // units
  input wire logic [MAG_W-1:0] first_residual_input, // residual 1
  input wire logic [MAG_W-1:0] second_residual_input, // residual 2
  input wire logic [MAG_W-1:0] calculated_residual, // from phases
  input wire logic [1:0] residual_source_select, // bft_res_sel_t
  input wire logic [3:0] mode_select, // bft_mode_t
  input wire logic [MAG_W-1:0] phase_pickup_threshold, // 10 per step
  input wire logic [MAG_W-1:0] residual_pickup_threshold, // 1 per step
  input wire logic retrip_enable, // retrip in use
  input wire logic [DLY_W-1:0] second_coil_delay, // retrip, ticks
  input wire logic [DLY_W-1:0] failure_delay, // failure, ticks
  input wire logic [NSIG-1:0] trip_signals, // protection trip events
  input wire logic [NSIG-1:0] signal_select, // which trips count
  input wire logic relay_monitor, // monitored output relay
  input wire logic block_in, // blocking input
  input wire logic [2:0] force_status, // bft_force_t
  output logic start_out, // start
  output logic retrip_out, // second coil
  output logic breaker_failure_output, // upstream trip
  output logic blocked_out, // blocked indication
  output logic [5:0] condition, // bft_state_t
  output logic tick_out // program cycle strobe
);
  localparam int TCW = $clog2(TICK_CYC);
  initial begin
    if (TICK_CYC < 2 || MAG_W < 11 || DLY_W < 2 || NSIG < 1)
      $error("bft_top: unsupported parameter values");
  end
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TCW-1:0] tdiv;
    logic tick;
    logic [DLY_W-1:0] rt_cnt;
    logic [DLY_W-1:0] bf_cnt;
    logic start;
    logic retrip;
    logic fail;
    logic blocked;
    logic [5:0] cond;
  } bft_st_t;
  bft_st_t st_r;
  bft_st_t st_nxt;
  logic [MAG_W-1:0] res_mag;
  logic [3:0] pu_ph;
  logic cur_pu;
  logic sig_act;
  logic pickup;
  logic run;
  logic mode_and;
  bft_pkg::bft_mode_t md;

  function automatic logic [DLY_W-1:0] sat_inc(input logic [DLY_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  always_comb begin
    case (bft_pkg::bft_res_sel_t'(residual_source_select))
      bft_pkg::BFT_RES_FIRST: res_mag = first_residual_input;
      bft_pkg::BFT_RES_SECOND: res_mag = second_residual_input;
      bft_pkg::BFT_RES_CALC: res_mag = calculated_residual;
      default: res_mag = '0;
    endcase
  end
  // ----------------------------------------------------------------
  // current pick-up, common phase threshold
  // ----------------------------------------------------------------
  bft_pickup #(.MAG_W(MAG_W)) u_pa (.sys_clk(sys_clk), .reset(reset),
    .tick(st_r.tick), .mag(phase_a_mag), .thr(phase_pickup_threshold),
    .picked(pu_ph[0]));
  bft_pickup #(.MAG_W(MAG_W)) u_pb (.sys_clk(sys_clk), .reset(reset),
    .tick(st_r.tick), .mag(phase_b_mag), .thr(phase_pickup_threshold),
    .picked(pu_ph[1]));
  bft_pickup #(.MAG_W(MAG_W)) u_pc (.sys_clk(sys_clk), .reset(reset),
    .tick(st_r.tick), .mag(phase_c_mag), .thr(phase_pickup_threshold),
    .picked(pu_ph[2]));
  bft_pickup #(.MAG_W(MAG_W)) u_pr (.sys_clk(sys_clk), .reset(reset),
    .tick(st_r.tick), .mag(res_mag), .thr(residual_pickup_threshold),
    .picked(pu_ph[3]));
  // unused residual source must never pick up, even at a zero threshold
  assign cur_pu = |pu_ph[2:0] |
    (pu_ph[3] && residual_source_select != bft_pkg::BFT_RES_NONE);
  // ----------------------------------------------------------------
  // operating mode combination
  // ----------------------------------------------------------------
  assign md = bft_pkg::bft_mode_t'(mode_select);
  assign mode_and = md[3];
  assign sig_act = md[1] && |(trip_signals & signal_select);
  always_comb begin
    if (md[2:0] == 3'h0)
      pickup = cur_pu;
    else if (mode_and)
      pickup = (!md[0] || cur_pu) && (!md[1] || sig_act) &&
               (!md[2] || relay_monitor);
    else
      pickup = (md[0] && cur_pu) || sig_act || (md[2] && relay_monitor);
  end
  assign run = pickup && !block_in;
  // ----------------------------------------------------------------
  // program cycle and timers
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.tdiv == TCW'(TICK_CYC - 1)) begin
      st_nxt.tdiv = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tdiv = st_r.tdiv + 1'b1;
    end
    if (st_r.tick) begin
      st_nxt.blocked = pickup && block_in;
      if (run) begin
        st_nxt.start = 1'b1;
        st_nxt.rt_cnt = sat_inc(st_r.rt_cnt);
        st_nxt.bf_cnt = sat_inc(st_r.bf_cnt);
        st_nxt.retrip = retrip_enable &&
          sat_inc(st_r.rt_cnt) >= second_coil_delay;
        st_nxt.fail = sat_inc(st_r.bf_cnt) >= failure_delay;
      end else begin
        st_nxt.start = 1'b0;
        st_nxt.retrip = 1'b0;
        st_nxt.fail = 1'b0;
        st_nxt.rt_cnt = '0;
        st_nxt.bf_cnt = '0;
      end
    end
    if (!retrip_enable)
      st_nxt.retrip = 1'b0;
    // status for display; forcing overrides outputs
    case (bft_pkg::bft_force_t'(force_status))
      bft_pkg::BFT_FORCE_START: begin
        st_nxt.start = 1'b1;
        st_nxt.retrip = 1'b0;
        st_nxt.fail = 1'b0;
        st_nxt.blocked = 1'b0;
      end
      bft_pkg::BFT_FORCE_RETRIP: begin
        st_nxt.start = 1'b1;
        st_nxt.retrip = retrip_enable;
        st_nxt.fail = 1'b0;
        st_nxt.blocked = 1'b0;
      end
      bft_pkg::BFT_FORCE_FAIL: begin
        st_nxt.start = 1'b1;
        st_nxt.fail = 1'b1;
        st_nxt.blocked = 1'b0;
      end
      bft_pkg::BFT_FORCE_BLOCKED: begin
        st_nxt.start = 1'b0;
        st_nxt.retrip = 1'b0;
        st_nxt.fail = 1'b0;
        st_nxt.blocked = 1'b1;
      end
      default: ;
    endcase
    if (st_nxt.blocked)
      st_nxt.cond = bft_pkg::BFT_ST_BLOCKED;
    else if (st_nxt.fail)
      st_nxt.cond = bft_pkg::BFT_ST_FAIL;
    else if (st_nxt.retrip)
      st_nxt.cond = bft_pkg::BFT_ST_RETRIP;
    else if (st_nxt.start)
      st_nxt.cond = bft_pkg::BFT_ST_START;
    else if (pickup)
      st_nxt.cond = bft_pkg::BFT_ST_ON;
    else
      st_nxt.cond = bft_pkg::BFT_ST_NORMAL;
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.cond <= bft_pkg::BFT_ST_NORMAL;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign start_out = st_r.start;
  assign retrip_out = st_r.retrip;
  assign breaker_failure_output = st_r.fail;
  assign blocked_out = st_r.blocked;
  assign condition = st_r.cond;
  assign tick_out = st_r.tick;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_block_clears: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.tick && block_in && force_status == 3'h0) |=> !start_out)
    else $error("start stayed up under blocking");
  a_block_flag: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.tick && pickup && block_in && force_status == 3'h0)
    |=> blocked_out)
    else $error("blocked indication missing");
  a_run_starts: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.tick && run && force_status == 3'h0) |=> start_out)
    else $error("start missing on unblocked pick-up");
  a_retrip_off: assert property (@(posedge sys_clk) disable iff (reset)
    !retrip_enable |=> !retrip_out)
    else $error("retrip output while disabled");
  a_retrip_time: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.tick && run && retrip_enable && force_status == 3'h0 &&
     st_r.rt_cnt + 1'b1 >= second_coil_delay && !(&st_r.rt_cnt))
    |=> retrip_out)
    else $error("retrip late");
  a_fail_time: assert property (@(posedge sys_clk) disable iff (reset)
    (breaker_failure_output && force_status == 3'h0)
    |-> st_r.bf_cnt >= failure_delay)
    else $error("failure output before its delay");
  a_idle_reset: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.tick && !run) |=> (st_r.rt_cnt == '0 && st_r.bf_cnt == '0))
    else $error("timers not reset on release");
  a_tick_period: assert property (@(posedge sys_clk) disable iff (reset)
    st_r.tick |=> !st_r.tick [*1] ##0 st_r.tdiv == TCW'(1))
    else $error("program cycle strobe irregular");
  a_halt_and: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.tick && md == 4'hd && !relay_monitor)
    |=> st_r.bf_cnt == '0)
    else $error("timer ran without monitored trip");
  // release paths checked for and mode 4'hd and or mode 4'h5: a wrong and/or split shows here first
  a_and_release: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.tick && md == 4'hd && (!cur_pu || !relay_monitor) &&
     force_status == 3'h0) |=> !start_out)
    else $error("and mode kept start after release");
  a_or_release: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.tick && md == 4'h5 && !cur_pu && !relay_monitor &&
     force_status == 3'h0) |=> !start_out)
    else $error("or mode kept start after release");
  a_sig_mask: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.tick && md == 4'h2 && !(|(trip_signals & signal_select)) &&
     force_status == 3'h0) |=> !start_out)
    else $error("unselected trip event started timing");
  a_cond_onehot: assert property (@(posedge sys_clk) disable iff (reset)
    $onehot(condition))
    else $error("condition status not one-hot");
  a_block_excl: assert property (@(posedge sys_clk) disable iff (reset)
    !(blocked_out && start_out))
    else $error("blocked and start together");
  a_fail_start: assert property (@(posedge sys_clk) disable iff (reset)
    breaker_failure_output |-> start_out)
    else $error("failure output without start");
  a_force_block: assert property (@(posedge sys_clk) disable iff (reset)
    (force_status == bft_pkg::BFT_FORCE_BLOCKED) |=>
    (blocked_out && !start_out && condition == bft_pkg::BFT_ST_BLOCKED))
    else $error("forced blocked status not applied");
  a_force_fail: assert property (@(posedge sys_clk) disable iff (reset)
    (force_status == bft_pkg::BFT_FORCE_FAIL) |=>
    (breaker_failure_output && start_out))
    else $error("forced failure status not applied");
endmodule : bft_top
`default_nettype wire

/* File: hw/bft_defs.svh */
`ifndef BFT_DEFS_SVH
`define BFT_DEFS_SVH
// ----------------------------------------------------------------
// scaling and timing
// ----------------------------------------------------------------
// magnitudes in units of 0.001 x nominal current
`define BFT_MAG_W 16
`define BFT_PH_STEP 16'd10
`define BFT_RES_STEP 16'd1
`define BFT_PH_DEF 16'd200
`define BFT_RES_DEF 16'd1200
// release ratio 97 percent: compare m*100 against thr*97
`define BFT_REL_NUM 8'd97
`define BFT_REL_DEN 8'd100
// delays in units of 5 ms program-cycle ticks
`define BFT_DLY_W 19
`define BFT_RETRIP_DEF 19'd20
`define BFT_FAIL_DEF 19'd40
`define BFT_TICK_NS 5000000
`define BFT_CLK_NS 25
// program cycle length in clocks
`define BFT_TICK_CYC (`BFT_TICK_NS / `BFT_CLK_NS)
`endif

/* File: hw/bft_pkg.sv */
package bft_pkg;
  typedef enum logic [1:0] {
    BFT_RES_NONE = 2'h0,
    BFT_RES_FIRST = 2'h1,
    BFT_RES_SECOND = 2'h2,
    BFT_RES_CALC = 2'h3
  } bft_res_sel_t;
  // mode: bit0 current, bit1 signals, bit2 output relay; bit3 1=and 0=or
  typedef logic [3:0] bft_mode_t;
  typedef enum logic [5:0] {
    BFT_ST_NORMAL = 6'h01,
    BFT_ST_START = 6'h02,
    BFT_ST_RETRIP = 6'h04,
    BFT_ST_FAIL = 6'h08,
    BFT_ST_ON = 6'h10,
    BFT_ST_BLOCKED = 6'h20
  } bft_state_t;
  typedef enum logic [2:0] {
    BFT_FORCE_NONE = 3'h0,
    BFT_FORCE_START = 3'h1,
    BFT_FORCE_RETRIP = 3'h2,
    BFT_FORCE_FAIL = 3'h3,
    BFT_FORCE_BLOCKED = 3'h4
  } bft_force_t;
endpackage : bft_pkg

/* File: hw/bft_pickup.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bft_defs.svh"
// ----------------------------------------------------------------
// one threshold comparator with 97 percent release hysteresis
// ----------------------------------------------------------------
module bft_pickup #(
  parameter int MAG_W = `BFT_MAG_W
) (
  input wire logic sys_clk, // clock
  input wire logic reset, // sync reset
  input wire logic tick, // program cycle strobe
  input wire logic [MAG_W-1:0] mag, // measured magnitude
  input wire logic [MAG_W-1:0] thr, // threshold
  output logic picked // pick-up level
);
  typedef struct packed {
    logic picked;
  } bft_pu_t;
  bft_pu_t st_r;
  bft_pu_t st_nxt;
  logic [MAG_W+7:0] m_scaled;
  logic [MAG_W+7:0] t_scaled;
  assign m_scaled = {8'h00, mag} * `BFT_REL_DEN;
  assign t_scaled = {8'h00, thr} * `BFT_REL_NUM;
  always_comb begin
    st_nxt = st_r;
    if (tick) begin
      if (mag > thr)
        st_nxt.picked = 1'b1;
      else if (m_scaled < t_scaled)
        st_nxt.picked = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign picked = st_r.picked;
  a_release_hyst: assert property (@(posedge sys_clk) disable iff (reset)
    (tick && picked && m_scaled >= t_scaled) |=> picked)
    else $error("pick-up released above the release level");
endmodule : bft_pickup
`default_nettype wire

/* File: tb/bft_breaker.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// feeder breaker with two trip coils and an upstream breaker
// ----------------------------------------------------------------
module bft_breaker #(
  parameter int OPEN_CYC = 30,
  parameter logic [15:0] FAULT_MAG = 16'h0190,
  parameter logic [15:0] LOAD_MAG = 16'h0032
) (
  input wire logic sys_clk, // clock
  input wire logic reset, // sync reset
  input wire logic trip_cmd, // primary trip command
  input wire logic retrip_cmd, // second coil command
  input wire logic upstream_cmd, // upstream feeder trip
  input wire logic coil1_ok, // first coil works
  input wire logic coil2_ok, // second coil works
  input wire logic fault, // fault current flowing
  output logic [15:0] mag, // phase a magnitude
  output logic relay_state // monitored trip relay
);
  int cnt;
  logic open_r;
  // contacts take OPEN_CYC+1 clocks to part once a healthy coil is energised
  always_ff @(posedge sys_clk) begin
    if (reset || (!fault && !trip_cmd)) begin
      cnt <= 0;
      open_r <= 1'b0;
    end else if ((trip_cmd && coil1_ok) || (retrip_cmd && coil2_ok)) begin
      if (cnt >= OPEN_CYC) open_r <= 1'b1;
      else cnt <= cnt + 1;
    end
  end
  assign mag = (open_r || upstream_cmd) ? 16'h0000 :
               (fault ? FAULT_MAG : LOAD_MAG);
  assign relay_state = trip_cmd;
endmodule : bft_breaker
`default_nettype wire

/* File: tb/bft_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module bft_top_test;
  localparam int NONE = -1;
  logic sys_clk = 1'b0, reset = 1'b1;
  logic [15:0] pa, pb = 16'h0, pc = 16'h0, r1 = 16'h0, r2 = 16'h0;
  logic [15:0] rc = 16'h0, pthr = 16'h00c8, rthr = 16'h04b0;
  logic [1:0] rsel = 2'h0;
  logic [3:0] mode = 4'h0;
  logic ren = 1'b1, relay, blk = 1'b0, fault = 1'b0, prim = 1'b0;
  logic c2 = 1'b0;
  logic [18:0] d1 = 19'h3, d2 = 19'h8;
  logic [7:0] trips = 8'h0, sel = 8'h0;
  logic [2:0] frc = 3'h0;
  logic start_out, retrip_out, breaker_failure_output, blocked_out, tick_out;
  logic [5:0] condition;
  int failures = 0, compares = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  bft_top #(.TICK_CYC(20)) i_bft_top (.sys_clk(sys_clk), .reset(reset),
    .phase_a_mag(pa), .phase_b_mag(pb), .phase_c_mag(pc),
    .first_residual_input(r1), .second_residual_input(r2),
    .calculated_residual(rc), .residual_source_select(rsel),
    .mode_select(mode), .phase_pickup_threshold(pthr),
    .residual_pickup_threshold(rthr), .retrip_enable(ren),
    .second_coil_delay(d1), .failure_delay(d2), .trip_signals(trips),
    .signal_select(sel), .relay_monitor(relay), .block_in(blk),
    .force_status(frc), .start_out(start_out), .retrip_out(retrip_out),
    .breaker_failure_output(breaker_failure_output),
    .blocked_out(blocked_out), .condition(condition),
    .tick_out(tick_out));
  bft_breaker i_bft_breaker (.sys_clk(sys_clk), .reset(reset),
    .trip_cmd(prim), .retrip_cmd(retrip_out),
    .upstream_cmd(breaker_failure_output), .coil1_ok(1'b0),
    .coil2_ok(c2), .fault(fault), .mag(pa), .relay_state(relay));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic go;
    @(posedge sys_clk);
    #2;
  endtask : go
  function automatic logic hit(input int w);
    case (w)
      0: hit = start_out === 1'b1;
      1: hit = retrip_out === 1'b1;
      2: hit = breaker_failure_output === 1'b1;
      3: hit = blocked_out === 1'b1;
      4: hit = start_out === 1'b0;
      default: hit = retrip_out === 1'b0;
    endcase
  endfunction : hit
  // ticks seen before the watched output reached its level, NONE if not reached within lim*20+2 clocks
  task automatic run(input int w, input int lim, output int n);
    n = 0;
    for (int i = 0; i < lim * 20 + 2; i++) begin
      go();
      if (hit(w)) return;
      if (tick_out === 1'b1) n++;
    end
    n = NONE;
  endtask : run
  task automatic close_out;
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [5:0] fexp [4];
    fexp = '{6'h02, 6'h04, 6'h08, 6'h20};
    repeat (3) go();
    reset = 1'b0;
    chk("idle", 32'h1, {start_out, retrip_out, breaker_failure_output,
        blocked_out, condition});
    fault = 1'b1;
    run(0, 4, n);
    chk("start", 2, n);
    chk("cond start", 32'h2, condition);
    run(1, 4, n);
    chk("retrip", 2, n);
    chk("cond retrip", 32'h4, condition);
    run(2, 8, n);
    chk("fail", 5, n);
    chk("cond fail", 32'h8, condition);
    fault = 1'b0;
    run(4, 4, n);
    chk("release", 2, n);
    c2 = 1'b1;
    fault = 1'b1;
    run(1, 6, n);
    chk("retrip up", 1, n >= 0);
    run(4, 6, n);
    chk("retrip clears", 1, n >= 0);
    chk("no fail", 0, breaker_failure_output);
    fault = 1'b0;
    ren = 1'b0;
    pb = 16'h00c9;
    run(0, 4, n);
    chk("start pb", 2, n);
    run(2, 9, n);
    chk("fail no retrip", 7, n);
    chk("retrip off", 0, retrip_out);
    pb = 16'h00c3;
    ren = 1'b1;
    run(4, 6, n);
    chk("hold 97", NONE, n);
    pb = 16'h00c1;
    run(4, 4, n);
    chk("below 97", 2, n);
    for (int s = 1; s < 4; s++) begin
      rsel = s[1:0];
      {r1, r2, rc} = {16'h0514, 16'h0000, 16'h0000} >> (16 * (s - 1));
      run(0, 4, n);
      chk("residual", 1, n >= 0);
      {r1, r2, rc} = '0;
      run(4, 4, n);
      chk("residual off", 1, n >= 0);
    end
    rsel = 2'h0;
    {r1, r2, rc} = {3{16'h0514}};
    run(0, 5, n);
    chk("unused", NONE, n);
    {r1, r2, rc} = '0;
    blk = 1'b1;
    pb = 16'h012c;
    run(3, 4, n);
    chk("blocked", 2, n);
    chk("cond blk", 32'h20, {start_out, condition});
    blk = 1'b0;
    run(0, 3, n);
    chk("unblock", 1, n);
    blk = 1'b1;
    run(4, 3, n);
    chk("block clears", 1, n);
    pb = 16'h0;
    blk = 1'b0;
    mode = 4'hd;
    fault = 1'b1;
    run(1, 12, n);
    chk("halted", NONE, n);
    prim = 1'b1;
    run(1, 6, n);
    chk("and runs", 1, n >= 0);
    prim = 1'b0;
    run(5, 4, n);
    chk("and reset", 1, n >= 0);
    fault = 1'b0;
    mode = 4'h5;
    prim = 1'b1;
    run(1, 6, n);
    chk("or trip", 1, n >= 0);
    prim = 1'b0;
    run(5, 4, n);
    chk("or reset", 1, n >= 0);
    fault = 1'b1;
    prim = 1'b1;
    run(0, 4, n);
    chk("or start", 1, n >= 0);
    prim = 1'b0;
    run(1, 4, n);
    chk("or holds", 1, n >= 0);
    fault = 1'b0;
    run(4, 6, n);
    chk("or release", 1, n >= 0);
    mode = 4'h2;
    trips = 8'h04;
    sel = 8'h02;
    run(0, 5, n);
    chk("unselected", NONE, n);
    sel = 8'h04;
    run(0, 4, n);
    chk("selected", 1, n >= 0);
    trips = 8'h0;
    run(4, 4, n);
    chk("signal off", 1, n >= 0);
    mode = 4'h0;
    for (int i = 1; i < 5; i++) begin
      frc = i[2:0];
      go();
      go();
      chk("forced", fexp[i - 1], condition);
    end
    frc = 3'h0;
    close_out();
  end
endmodule : bft_top_test
`default_nettype wire
